// ### pwmc_top.sv
/*
 * Eight-channel PWM generator with left or center alignment, double
 * buffered period and duty, boundary outputs and 16-bit pair joining.
 * Assumes tick inputs come from prescaler logic on the same clock and
 * that software keeps register writes to the plain register port.
 */
// Decided for this implementation: the address map and the plain strobed port.
// Notes on behaviour
// RULE_01: Align bit set selects center-aligned waveform
// RULE_02: Center mode counts up/down; up at zero
// RULE_03: Output toggles at duty match both directions
// RULE_04: Period match while up reverses to down
// RULE_05: Zero while down: up again, reload buffers
// RULE_06: Effective center period is twice period value
// RULE_07: Software sets alignment before enabling channel
// RULE_08: Four pair-join bits make 16-bit channels
// RULE_09: Software changes join bits with pair disabled
// RULE_10: Even channel holds high byte when joined
// RULE_11: Odd clock select and odd pin serve pair
// RULE_12: Odd polarity sets joined waveform start level
// RULE_13: Odd enable runs pair; even output disabled
// RULE_14: Any counter byte write resets joined counter
// RULE_15: Software reads joined counter in one access
// RULE_16: Odd align bit selects joined pair alignment
// RULE_17: Zero or full duty force constant output
// RULE_18: Zero period holds counter, output equals polarity
// RULE_19: Period and duty double buffered, specific loads
// RULE_20: Counter write clears, up, loads, sets polarity
// RULE_21: Polarity one starts high, low at duty
// RULE_22: Joined pair compares full 16-bit values
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Next-state step of one counter, up to 16 bits wide
// ----------------------------------------------------------------------
module pwmc_step #(
    parameter int W = 16
) (
    input wire logic [W-1:0] cnt,      // Current count
    input wire logic [W-1:0] per,      // Active period
    input wire logic [W-1:0] dty,      // Active duty
    input wire logic down,             // Counting down
    input wire logic center,           // Center-aligned mode
    output logic [W-1:0] cntN,         // Next count
    output logic downN,                // Next direction
    output logic toggle,               // Duty match on next count
    output logic periodEnd             // Effective period ends
);
    always_comb begin
        cntN = cnt;
        downN = down;
        periodEnd = 1'b0;
        if (per == '0) begin
            cntN = '0;                                  // [RULE_18]
            downN = 1'b0;
        end else if (!center) begin
            downN = 1'b0;
            if (W'(cnt + W'(1)) >= per) begin
                cntN = '0;
                periodEnd = 1'b1;
            end else begin
                cntN = W'(cnt + W'(1));
            end
        end else if (down && cnt != '0) begin           // [RULE_01] [RULE_02]
            cntN = W'(cnt - W'(1));
            if (cntN == '0) begin
                downN = 1'b0;                           // [RULE_05]
                periodEnd = 1'b1;                       // [RULE_06]
            end
        end else if (cnt >= per) begin
            cntN = W'(cnt - W'(1));                     // [RULE_04]
            downN = 1'b1;
        end else begin
            cntN = W'(cnt + W'(1));                     // [RULE_02]
            downN = 1'b0;
        end
    end

    assign toggle = !periodEnd && cntN == dty;          // [RULE_03] [RULE_22]
endmodule

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module pwmc_top (
    input wire logic clock,                 // 250 MHz clock
    input wire logic nrst,                  // Synchronous reset, active low
    input wire logic clkEn,                 // Freezes all state while low
    input wire logic [5:0] addr,            // Register address
    input wire logic [7:0] wrData,          // Write data
    input wire logic wrStb,                 // Write strobe
    input wire logic rdStb,                 // Read strobe
    output logic [7:0] rdData,              // Read data, cycle after strobe
    input wire logic tickA,                 // Channel clock source A
    input wire logic tickB,                 // Channel clock source B
    output logic [7:0] channelOutputPin     // PWM outputs
);
    localparam int N = pwmc_pkg::NUM_CH;
    localparam int WW = pwmc_pkg::WIDE_W;

    // ------------------------------------------------------------------
    // Registers and per-channel nets
    // ------------------------------------------------------------------
    logic [7:0] enableQ;
    logic [7:0] polarityQ;
    logic [7:0] clkSelQ;
    logic [7:0] alignQ;
    logic [3:0] joinQ;
    logic [7:0] cntQ [N];
    logic [7:0] perBufQ [N];
    logic [7:0] dtyBufQ [N];
    logic [7:0] perActQ [N];
    logic [7:0] dtyActQ [N];
    logic [7:0] downQ;
    logic [7:0] outQ;
    logic [7:0] pinQ;
    logic [7:0] rdDataQ;

    logic [7:0] running;
    logic [7:0] step;
    logic [7:0] cntWr;
    logic [7:0] cntRst;
    logic [7:0] reload;
    logic [7:0] perWr;
    logic [7:0] dtyWr;
    logic [7:0] pairStep;
    logic [7:0] pairRun;
    logic [7:0] pairEnd;
    logic [7:0] cntNext [N];
    logic [7:0] downN;
    logic [7:0] toggle;
    logic [7:0] periodEnd;
    logic [7:0] pinN;
    logic [WW-1:0] cntW [N];
    logic [WW-1:0] perW [N];
    logic [WW-1:0] dtyW [N];
    logic [WW-1:0] cntWN [N];

    // ------------------------------------------------------------------
    // Per-channel datapath
    // ------------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_ch
        localparam bit IS_ODD = (i % 2) == 1;
        localparam int MATE = i ^ 1;
        logic joined;
        logic wideHi;

        assign joined = joinQ[i / 2];                                   // [RULE_08]
        assign wideHi = IS_ODD && joined;
        // Even channel of a joined pair never runs on its own
        assign running[i] = enableQ[i] && !(!IS_ODD && joined);         // [RULE_13]
        assign step[i] = running[i] && (clkSelQ[i] ? tickB : tickA);    // [RULE_11]
        assign cntWr[i] = wrStb && addr == 6'(pwmc_pkg::OFF_COUNTER + i);
        assign perWr[i] = wrStb && addr == 6'(pwmc_pkg::OFF_PERIOD + i);
        assign dtyWr[i] = wrStb && addr == 6'(pwmc_pkg::OFF_DUTY + i);
        assign cntRst[i] = cntWr[i] || (joined && cntWr[MATE]);         // [RULE_14]

        // Even byte is high order when joined
        assign cntW[i] = {wideHi ? cntQ[MATE] : 8'h00, cntQ[i]};        // [RULE_10]
        assign perW[i] = {wideHi ? perActQ[MATE] : 8'h00, perActQ[i]};
        assign dtyW[i] = {wideHi ? dtyActQ[MATE] : 8'h00, dtyActQ[i]};

        pwmc_step #(.W(WW)) u_step (
            .cnt(cntW[i]),
            .per(perW[i]),
            .dty(dtyW[i]),
            .down(downQ[i]),
            .center(alignQ[i]),                                         // [RULE_16]
            .cntN(cntWN[i]),
            .downN(downN[i]),
            .toggle(toggle[i]),
            .periodEnd(periodEnd[i])
        );

        // Governing channel of the pair is the odd one when joined
        assign pairStep[i] = joined ? step[i | 1] : step[i];
        assign pairRun[i] = joined ? running[i | 1] : running[i];
        assign pairEnd[i] = joined ? periodEnd[i | 1] : periodEnd[i];
        assign cntNext[i] = (joined && !IS_ODD) ? cntWN[i | 1][15:8] : cntWN[i][7:0];
        assign reload[i] = cntRst[i] || !pairRun[i] || (pairStep[i] && pairEnd[i]);

        // Boundary cases override the toggling flip-flop
        always_comb begin
            if (!running[i]) begin
                pinN[i] = 1'b0;
            end else if (perW[i] == '0) begin
                pinN[i] = polarityQ[i];                                 // [RULE_18]
            end else if (dtyW[i] == '0) begin
                pinN[i] = !polarityQ[i];                                // [RULE_17]
            end else if (dtyW[i] >= perW[i]) begin
                pinN[i] = polarityQ[i];                                 // [RULE_17]
            end else begin
                pinN[i] = outQ[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            enableQ <= pwmc_pkg::RST_ENABLE;
            polarityQ <= pwmc_pkg::RST_POLARITY;
            clkSelQ <= pwmc_pkg::RST_CLKSEL;
            alignQ <= pwmc_pkg::RST_ALIGN;
            joinQ <= pwmc_pkg::RST_JOIN;
        end else if (clkEn && wrStb) begin
            unique case (addr)
                pwmc_pkg::OFF_ENABLE: enableQ <= wrData;
                pwmc_pkg::OFF_POLARITY: polarityQ <= wrData;
                pwmc_pkg::OFF_CLKSEL: clkSelQ <= wrData;
                pwmc_pkg::OFF_ALIGN: alignQ <= wrData;
                pwmc_pkg::OFF_CONTROL: joinQ <= wrData[pwmc_pkg::POS_JOIN_6_7:
                                                       pwmc_pkg::POS_JOIN_0_1];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Period and duty, buffered and active
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                perBufQ[i] <= pwmc_pkg::RST_PERIOD;
                dtyBufQ[i] <= pwmc_pkg::RST_DUTY;
            end
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                if (perWr[i]) begin
                    perBufQ[i] <= wrData;
                end
                if (dtyWr[i]) begin
                    dtyBufQ[i] <= wrData;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                perActQ[i] <= pwmc_pkg::RST_PERIOD;
                dtyActQ[i] <= pwmc_pkg::RST_DUTY;
            end
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                // Stopped channel follows its buffer, so writes land directly
                if (reload[i]) begin                                    // [RULE_19] [RULE_05]
                    perActQ[i] <= perBufQ[i];
                    dtyActQ[i] <= dtyBufQ[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Counters, direction and output flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                cntQ[i] <= pwmc_pkg::RST_COUNTER;
            end
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                if (cntRst[i]) begin
                    cntQ[i] <= 8'h00;                                   // [RULE_20] [RULE_14]
                end else if (pairStep[i]) begin
                    cntQ[i] <= cntNext[i];                              // [RULE_06]
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            downQ <= 8'h00;
            outQ <= 8'h00;
        end else if (clkEn) begin
            for (int i = 0; i < N; i++) begin
                if (cntRst[i]) begin
                    downQ[i] <= 1'b0;                                   // [RULE_20]
                    outQ[i] <= polarityQ[i];
                end else if (step[i]) begin
                    downQ[i] <= downN[i];                               // [RULE_04]
                    if (periodEnd[i]) begin
                        outQ[i] <= polarityQ[i];                        // [RULE_21] [RULE_12]
                    end else if (toggle[i]) begin
                        outQ[i] <= !outQ[i];                            // [RULE_03]
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pinQ <= 8'h00;
        end else if (clkEn) begin
            pinQ <= pinN;                                               // [RULE_13] [RULE_11]
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdDataQ <= 8'h00;
        end else if (clkEn) begin
            rdDataQ <= 8'h00;
            if (rdStb) begin
                if (addr == pwmc_pkg::OFF_ENABLE) begin
                    rdDataQ <= enableQ;
                end else if (addr == pwmc_pkg::OFF_POLARITY) begin
                    rdDataQ <= polarityQ;
                end else if (addr == pwmc_pkg::OFF_CLKSEL) begin
                    rdDataQ <= clkSelQ;
                end else if (addr == pwmc_pkg::OFF_ALIGN) begin
                    rdDataQ <= alignQ;
                end else if (addr == pwmc_pkg::OFF_CONTROL) begin
                    rdDataQ <= {joinQ, 4'h0};
                end else if (addr[5:3] == pwmc_pkg::OFF_COUNTER[5:3]) begin
                    rdDataQ <= cntQ[addr[2:0]];
                end else if (addr[5:3] == pwmc_pkg::OFF_PERIOD[5:3]) begin
                    rdDataQ <= perBufQ[addr[2:0]];
                end else if (addr[5:3] == pwmc_pkg::OFF_DUTY[5:3]) begin
                    rdDataQ <= dtyBufQ[addr[2:0]];
                end
            end
        end
    end

    assign rdData = rdDataQ;
    assign channelOutputPin = pinQ;
endmodule

// ### pwmc_pkg.sv
/*
 * Package for the center-aligned, pair-joinable eight-channel PWM block.
 * Holds register offsets, widths and reset values of the register port.
 * Assumes a single 250 MHz clock and byte-wide registers on a plain port.
 */
package pwmc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int NUM_PAIR = 4;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int WIDE_W = 16;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_ENABLE = 6'h00;   // channel_enable_bit per channel
    localparam logic [5:0] OFF_POLARITY = 6'h01; // polarity_reg
    localparam logic [5:0] OFF_CLKSEL = 6'h02;   // clock_select_bit per channel
    localparam logic [5:0] OFF_ALIGN = 6'h03;    // align_select_reg
    localparam logic [5:0] OFF_CONTROL = 6'h04;  // pwm_control_reg, pair joins
    localparam logic [5:0] OFF_COUNTER = 6'h08;  // channel_counter 0..7
    localparam logic [5:0] OFF_PERIOD = 6'h10;   // period_value 0..7
    localparam logic [5:0] OFF_DUTY = 6'h18;     // duty_value 0..7

    // ------------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------------
    localparam int POS_JOIN_0_1 = 4;
    localparam int POS_JOIN_2_3 = 5;
    localparam int POS_JOIN_4_5 = 6;
    localparam int POS_JOIN_6_7 = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [7:0] RST_CLKSEL = 8'h00;
    localparam logic [7:0] RST_ALIGN = 8'h00;
    localparam logic [3:0] RST_JOIN = 4'h0;
    localparam logic [7:0] RST_COUNTER = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_DUTY = 8'h00;

endpackage

// ### pwmc_top_properties.sv
/*
 * Port checker for the eight-channel PWM block, bound to pwmc_top.
 * Assumes one clock, synchronous active-low reset and byte registers.
 */
`timescale 1ns/10ps
module pwmc_top_checker (
    input wire logic clock,                 // Clock
    input wire logic nrst,                  // Reset, active low
    input wire logic clkEn,                 // Clock enable
    input wire logic [5:0] addr,            // Register address
    input wire logic [7:0] wrData,          // Write data
    input wire logic wrStb,                 // Write strobe
    input wire logic rdStb,                 // Read strobe
    input wire logic [7:0] rdData,          // Read data
    input wire logic tickA,                 // Tick source A
    input wire logic tickB,                 // Tick source B
    input wire logic [7:0] channelOutputPin // PWM outputs
);
    logic [7:0] enQ, enQ1, enQ2;
    logic [3:0] joinQ, joinQ1, joinQ2;
    logic [3:0] joinSt;
    logic wrEn;
    logic evt;
    assign wrEn = clkEn && wrStb;
    assign evt = clkEn && (tickA || tickB || wrStb);
    assign joinSt = joinQ & joinQ1 & joinQ2;

    // ------------------------------------------------------------------
    // Shadows of enable and join bits
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            {enQ, enQ1, enQ2} <= 24'h000000;
        end else if (clkEn) begin
            if (wrStb && addr == pwmc_pkg::OFF_ENABLE) begin
                enQ <= wrData;
            end
            {enQ2, enQ1} <= {enQ1, enQ};
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            {joinQ, joinQ1, joinQ2} <= 12'h000;
        end else if (clkEn) begin
            if (wrStb && addr == pwmc_pkg::OFF_CONTROL) begin
                joinQ <= wrData[7:4];
            end
            {joinQ2, joinQ1} <= {joinQ1, joinQ};
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    property readBack_p;
        logic [5:0] a;
        logic [7:0] d;
        (wrEn && addr[5:4] == 2'h1, a = addr, d = wrData) ##1 !wrStb
            ##1 (clkEn && rdStb && addr == a) |=> rdData == d;
    endproperty
    property ctlRead_p;
        logic [7:0] d;
        (wrEn && addr == pwmc_pkg::OFF_CONTROL, d = wrData) ##1 !wrStb
            ##1 (clkEn && rdStb && addr == pwmc_pkg::OFF_CONTROL) |=> rdData == {d[7:4], 4'h0};
    endproperty
    property joinClr_p;
        logic [5:0] a;
        (wrEn && addr[5:3] == 3'h1 && joinQ[addr[2:1]] && !enQ[{addr[2:1], 1'b1}], a = addr)
            ##1 !wrStb ##1 (clkEn && rdStb && addr == {a[5:1], ~a[0]}) |=> rdData == 8'h00;
    endproperty
    property selfClr_p;
        logic [5:0] a;
        (wrEn && addr[5:3] == 3'h1 && !enQ[addr[2:0]], a = addr) ##1 !wrStb
            ##1 (clkEn && rdStb && addr == a) |=> rdData == 8'h00;
    endproperty

    buf_read_a: assert property (readBack_p) else $error("period or duty read back wrong");
    join_read_a: assert property (ctlRead_p) else $error("control read back wrong");
    join_clear_a: assert property (joinClr_p) else $error("joined counter not cleared");
    count_clear_a: assert property (selfClr_p) else $error("counter not cleared");
    unmapped_zero_a: assert property (clkEn && rdStb && (addr >= 6'h20 || addr inside {6'h05, 6'h06,
        6'h07}) |=> rdData == 8'h00) else $error("unmapped read not zero");
    even_off_a: assert property ((channelOutputPin & {1'b0, joinSt[3], 1'b0, joinSt[2], 1'b0,
        joinSt[1], 1'b0, joinSt[0]}) == 8'h00) else $error("joined even pin driven");
    disabled_low_a: assert property ((channelOutputPin & ~(enQ | enQ1 | enQ2)) == 8'h00)
        else $error("disabled channel pin driven");
    pin_cause_a: assert property ($changed(channelOutputPin) |-> $past(evt, 2) || $past(evt, 3))
        else $error("pin changed without tick or write");
    freeze_a: assert property (!clkEn |=> $stable(channelOutputPin) && $stable(rdData))
        else $error("state moved with clock enable low");

    cover property (wrEn && addr == pwmc_pkg::OFF_CONTROL && wrData[4]);
    cover property (channelOutputPin[1] && joinSt[0]);
    cover property ($rose(channelOutputPin[0]));
endmodule

bind pwmc_top pwmc_top_checker u_chk (.clock(clock), .nrst(nrst), .clkEn(clkEn), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .tickA(tickA),
    .tickB(tickB), .channelOutputPin(channelOutputPin));

// ### test_pwm_center_align_concat.sv
/*
 * Self-checking bench for pwmc_top: waveform table, joined pair, bus edges.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_pwm_center_align_concat;
    logic clock, nrst, clkEn, wrStb, rdStb, tickA, tickB;
    logic [5:0] addr;
    logic [7:0] wrData, rdData, pin, p0;
    int mismatches, testsRun, hi, rs;
    typedef struct {logic [7:0] al, pl, cs, pr, dt; int hi, rs;} pwmc_wave_s;
    pwmc_wave_s rows [10];

    pwmc_top DUT (.clock(clock), .nrst(nrst), .clkEn(clkEn), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .tickA(tickA), .tickB(tickB),
        .channelOutputPin(pin));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) tickB <= ~tickB;

    // ------------------------------------------------------------------
    // Bus and measurement tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clock);
        wrStb <= 1'b0;
    endtask
    task automatic rdChk(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        @(posedge clock);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clock);
        rdStb <= 1'b0;
        #1 d = rdData;
        `CHK(nm, e, d)
    endtask
    task automatic meas(input int ch, output int h, output int r);
        logic p;
        #1 p = pin[ch];
        h = 0;
        r = 0;
        repeat (16) begin
            @(posedge clock);
            #1 h += pin[ch];
            r += (pin[ch] && !p);
            p = pin[ch];
        end
    endtask
    task automatic prog(input pwmc_wave_s r);
        wr(pwmc_pkg::OFF_ENABLE, 8'h00);
        wr(pwmc_pkg::OFF_ALIGN, r.al);
        wr(pwmc_pkg::OFF_POLARITY, r.pl);
        wr(pwmc_pkg::OFF_CLKSEL, r.cs);
        wr(pwmc_pkg::OFF_PERIOD, r.pr);
        wr(pwmc_pkg::OFF_DUTY, r.dt);
        wr(pwmc_pkg::OFF_COUNTER, 8'h00);
        wr(pwmc_pkg::OFF_ENABLE, 8'h01);
        repeat (6) @(posedge clock);
    endtask
    task test_done;
        $display("Counts: %0d checks, %0d mismatches", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        $display("[ERR] watchdog expired");
        test_done();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {nrst, clkEn, wrStb, rdStb, tickA, tickB} = 6'b010010;
        addr = 6'h00;
        wrData = 8'h00;
        rows = '{'{8'h01, 8'h00, 8'h00, 8'h04, 8'h01, 12, 2}, '{8'h01, 8'h01, 8'h00, 8'h04, 8'h01, 4, 2},
            '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 12, 4}, '{8'h01, 8'h00, 8'h00, 8'h08, 8'h03, 10, 1},
            '{8'h01, 8'h00, 8'h01, 8'h04, 8'h01, 12, 1}, '{8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 16, 0},
            '{8'h01, 8'h01, 8'h00, 8'h04, 8'h00, 0, 0}, '{8'h01, 8'h00, 8'h00, 8'h04, 8'h04, 0, 0},
            '{8'h01, 8'h01, 8'h00, 8'h04, 8'h05, 16, 0}, '{8'h01, 8'h01, 8'h00, 8'h00, 8'h02, 16, 0}};
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rdChk("enable reset", pwmc_pkg::OFF_ENABLE, pwmc_pkg::RST_ENABLE);
        rdChk("period reset", pwmc_pkg::OFF_PERIOD + 6'h05, pwmc_pkg::RST_PERIOD);
        rdChk("duty reset", pwmc_pkg::OFF_DUTY, pwmc_pkg::RST_DUTY);
        rdChk("control reset", pwmc_pkg::OFF_CONTROL, 8'h00);
        $display("Test reset done");
        foreach (rows[i]) begin
            prog(rows[i]);
            meas(0, hi, rs);
            `CHK("high cycles", rows[i].hi, hi)
            `CHK("rising edges", rows[i].rs, rs)
        end
        $display("Test waveforms done");
        prog(rows[0]);
        wr(pwmc_pkg::OFF_PERIOD, 8'h08);
        rdChk("period buffer", pwmc_pkg::OFF_PERIOD, 8'h08);
        @(posedge clock);
        clkEn <= 1'b0;
        #1 p0 = pin;
        repeat (8) @(posedge clock);
        #1 `CHK("frozen pins", p0, pin)
        clkEn <= 1'b1;
        wr(pwmc_pkg::OFF_ENABLE, 8'h00);
        wr(pwmc_pkg::OFF_COUNTER, 8'h00);
        rdChk("counter cleared", pwmc_pkg::OFF_COUNTER, 8'h00);
        $display("Test buffer and freeze done");
        wr(pwmc_pkg::OFF_CONTROL, 8'hff);
        rdChk("control bits", pwmc_pkg::OFF_CONTROL, 8'hf0);
        wr(6'h05, 8'h5a);
        rdChk("unmapped low", 6'h05, 8'h00);
        rdChk("unmapped high", 6'h3f, 8'h00);
        wr(pwmc_pkg::OFF_CONTROL, 8'h10);
        wr(pwmc_pkg::OFF_ALIGN, 8'h02);
        wr(pwmc_pkg::OFF_DUTY, 8'h00);
        wr(pwmc_pkg::OFF_POLARITY, 8'h01);
        wr(pwmc_pkg::OFF_CLKSEL, 8'h01);
        wr(pwmc_pkg::OFF_PERIOD, 8'h00);
        wr(pwmc_pkg::OFF_PERIOD + 6'h01, 8'h08);
        wr(pwmc_pkg::OFF_DUTY + 6'h01, 8'h03);
        wr(pwmc_pkg::OFF_COUNTER + 6'h01, 8'h00);
        wr(pwmc_pkg::OFF_ENABLE, 8'h03);
        repeat (6) @(posedge clock);
        meas(1, hi, rs);
        `CHK("joined high", 10, hi)
        `CHK("joined rises", 1, rs)
        meas(0, hi, rs);
        `CHK("even pin high", 0, hi)
        wr(pwmc_pkg::OFF_ENABLE, 8'h00);
        wr(pwmc_pkg::OFF_COUNTER, 8'h00);
        rdChk("joined low count", pwmc_pkg::OFF_COUNTER + 6'h01, 8'h00);
        wr(pwmc_pkg::OFF_DUTY, 8'h01);
        wr(pwmc_pkg::OFF_DUTY + 6'h01, 8'h00);
        wr(pwmc_pkg::OFF_COUNTER + 6'h01, 8'h00);
        wr(pwmc_pkg::OFF_ENABLE, 8'h02);
        repeat (6) @(posedge clock);
        meas(1, hi, rs);
        `CHK("joined full duty", 0, hi)
        wr(pwmc_pkg::OFF_ENABLE, 8'h00);
        wr(pwmc_pkg::OFF_CONTROL, 8'h00);
        $display("Test joined pair done");
        test_done();
    end
endmodule
